// ### hw/sbc_params.svh
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH
// register addresses on the serial link
`define SBC_ADDR_BRIDGE  5'h01
`define SBC_ADDR_HBCTL   5'h02
`define SBC_ADDR_SYSTEM_CONTROL_REG  5'h03
`define SBC_ADDR_ASEL    5'h07
`define SBC_ADDR_POWER_OUTPUT_REG    5'h0B
`define SBC_ADDR_STATUS  5'h0C
// field positions
`define SBC_BIT_POWER_STAGES_ENABLE     7
`define SBC_BIT_OFC      7
`define SBC_BIT_LIN_CURRENT_LIMIT_FLAG    6
`define SBC_BIT_OCF      1
`define SBC_BIT_SUPPLY   1
// writable masks and reset value
`define SBC_MASK_HBCTL   8'hC7
`define SBC_MASK_SYSTEM_CONTROL_REG  8'hE0
`define SBC_MASK_ASEL    8'h0F
`define SBC_MASK_POWER_OUTPUT_REG    8'h02
`define SBC_RESET_VAL    8'h00
// serial frame length in sampling edges
`define SBC_FRAME_BITS   5'd16
// lowest current limit code that enables chopping
`define SBC_CLS_MIN      3'h3
`endif

// ### hw/sbc_pkg.sv
`default_nettype none
package sbc_pkg;
    // serial link pins after synchronisation
    typedef struct packed {
        logic sel_n;
        logic sck;
        logic mosi;
    } sbc_link_s;
    // analog mux channel codes
    typedef enum logic [3:0] {
        SBC_CH_HB1  = 4'h0,
        SBC_CH_HB2  = 4'h1,
        SBC_CH_HB3  = 4'h2,
        SBC_CH_HB4  = 4'h3,
        SBC_CH_VSUP = 4'h4,
        SBC_CH_TEMP = 4'h5
    } sbc_chan_e;
    // serial transfer states
    typedef enum logic [2:0] {
        SBC_IDLE = 3'b001,
        SBC_SHIFT = 3'b010,
        SBC_DONE = 3'b100
    } sbc_state_e;
endpackage
`default_nettype wire

// ### hw/sbc_ctrl.sv
`include "sbc_params.svh"
`default_nettype none
// Operation
// R1: first reply byte is the system status register, always.
// R2: second reply byte is addressed register, old value on writes.
// R3: LIN transmitter disabled unless power stages enable is set.
// R4: LIN current limit flag set while transmitter limits current.
// R5: host should watch LIN limit flag and switch transmitter off.
// R6: transmit low drives bus dominant; high or open leaves recessive.
// R7: receive output follows bus: high recessive, low dominant.
// R8: mux select codes 0-5 route channels; others unused; reset code 0.
// R9: switched supply on while its power output bit is set; code also requires power stages enable.
// R10: host writes zero to unused power output bits.
// R11: reset clears bridge switch register, all MOSFETs off.
// R12: one bit per MOSFET, bridge4 high at bit7 to bridge1 low at bit0.
// R13: power stages enable gates all MOSFET drive.
// R14: both bits set in a bridge: only high side turns on.
// R15: a MOSFET turns on only after its partner is confirmed off.
// R16: low side off above limit, back on at frequency rising edge.
// R17: five selectable current limit levels.
// R18: host keeps chop frequency between 0.1 and 20 kHz.
// R19: offset chopping: bridges 1-2 rising edge, bridges 3-4 falling edge.
// R20: without offset chopping all bridges re-arm on rising edge.
// R21: limit codes 0-2 no limit, 3-7 five increasing levels.
// R22: transfer valid only with exactly 16 edges; write stored at select rise.
// R23: overcurrent turns side off, sets flag; write one or reset clears.
module sbc_ctrl (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    // serial register link
    input  wire logic        i_link_sel_n,
    input  wire logic        i_link_sck,
    input  wire logic        i_link_mosi,
    output logic             o_link_miso,
    output logic             o_link_miso_oe,
    // LIN transceiver
    input  wire logic        i_lin_tx,
    input  wire logic        i_lin_bus,
    input  wire logic        i_lin_climit,
    output logic             o_lin_drive,
    output logic             o_lin_rx,
    // analog sensing and supply
    output logic [3:0]       o_analog_select,
    output logic             o_switched_supply_output,
    // half-bridges
    input  wire logic [3:0]  i_hs_gate_off,
    input  wire logic [3:0]  i_ls_gate_off,
    input  wire logic [3:0]  i_ls_over_limit,
    input  wire logic        i_hs_overcurrent,
    input  wire logic        i_ls_overcurrent,
    input  wire logic        i_chop_frequency_input,
    output logic [3:0]       o_hs_on,
    output logic [3:0]       o_ls_on,
    output logic [2:0]       o_current_limit_select
);
    // two-stage synchronisers for all pins except the two overcurrent inputs
    logic [2:0] link_s1_q, link_s2_q;
    logic [3:0] misc_s1_q, misc_s2_q;
    logic [7:0] gate_s1_q, gate_s2_q;
    logic [3:0] lim_s1_q, lim_s2_q;
    sbc_pkg::sbc_link_s lk;
    logic       sck_prev_q, sel_prev_q, fg_prev_q;
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            link_s1_q <= 3'h5;
            link_s2_q <= 3'h5;
            // tx and bus idle recessive high, frequency low: no false edge after reset
            misc_s1_q <= 4'hC;
            misc_s2_q <= 4'hC;
            gate_s1_q <= 8'hFF;
            gate_s2_q <= 8'hFF;
            lim_s1_q  <= 4'h0;
            lim_s2_q  <= 4'h0;
        end else begin
            link_s1_q <= {i_link_sel_n, i_link_sck, i_link_mosi};
            link_s2_q <= link_s1_q;
            misc_s1_q <= {i_lin_tx, i_lin_bus, i_lin_climit, i_chop_frequency_input};
            misc_s2_q <= misc_s1_q;
            gate_s1_q <= {i_hs_gate_off, i_ls_gate_off};
            gate_s2_q <= gate_s1_q;
            lim_s1_q  <= i_ls_over_limit;
            lim_s2_q  <= lim_s1_q;
        end
    end
    assign lk = link_s2_q;
    wire tx_s   = misc_s2_q[3];
    wire bus_s  = misc_s2_q[2];
    wire clim_s = misc_s2_q[1];
    wire fg_s   = misc_s2_q[0];
    wire [3:0] hs_off_s = gate_s2_q[7:4];
    wire [3:0] ls_off_s = gate_s2_q[3:0];

    // edge detection on synchronised link and frequency pins
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sck_prev_q <= 1'b0;
            sel_prev_q <= 1'b1;
            fg_prev_q  <= 1'b0;
        end else begin
            sck_prev_q <= lk.sck;
            sel_prev_q <= lk.sel_n;
            fg_prev_q  <= fg_s;
        end
    end
    wire sck_rise = lk.sck & ~sck_prev_q;
    wire sck_fall = ~lk.sck & sck_prev_q;
    wire sel_fall = ~lk.sel_n & sel_prev_q;
    wire sel_rise = lk.sel_n & ~sel_prev_q;
    wire fg_rise  = fg_s & ~fg_prev_q;
    wire fg_fall  = ~fg_s & fg_prev_q;

    // registers
    logic [7:0] bridge_switch_q, hbctl_q, system_control_reg_q, asel_q, power_output_reg_q;
    logic       ocf_q;
    wire        power_stages_enable = system_control_reg_q[`SBC_BIT_POWER_STAGES_ENABLE];
    wire [7:0]  status = {1'b0, clim_s & power_stages_enable, 4'h0, ocf_q, 1'b0};  // [R4]

    function automatic logic [7:0] sbc_read(input logic [4:0] a);
        unique case (a)
            `SBC_ADDR_BRIDGE: sbc_read = bridge_switch_q;
            `SBC_ADDR_HBCTL:  sbc_read = hbctl_q;
            `SBC_ADDR_SYSTEM_CONTROL_REG: sbc_read = system_control_reg_q;
            `SBC_ADDR_ASEL:   sbc_read = asel_q;
            `SBC_ADDR_POWER_OUTPUT_REG:   sbc_read = power_output_reg_q;
            `SBC_ADDR_STATUS: sbc_read = status;
            default:          sbc_read = 8'h00;
        endcase
    endfunction

    // serial transfer: 16 bits, mosi sampled on falling sck, miso moves on rising
    sbc_pkg::sbc_state_e st_q;
    logic [4:0]  cnt_q;
    logic [15:0] rx_q;
    logic [15:0] tx_q;
    logic        miso_q;
    wire         wr_ok = sel_rise && cnt_q == `SBC_FRAME_BITS && !rx_q[15];  // [R22]
    wire [4:0]   wr_addr = rx_q[14:10];
    wire [7:0]   wr_data = rx_q[7:0];
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q   <= sbc_pkg::SBC_IDLE;
            cnt_q  <= 5'h00;
            rx_q   <= 16'h0000;
            tx_q   <= 16'h0000;
            miso_q <= 1'b0;
        end else begin
            unique case (st_q)
                sbc_pkg::SBC_IDLE: if (sel_fall) begin
                    st_q  <= sbc_pkg::SBC_SHIFT;
                    cnt_q <= 5'h00;
                    tx_q  <= {status, 8'h00};  // [R1]
                end
                sbc_pkg::SBC_SHIFT: begin
                    if (sel_rise) st_q <= sbc_pkg::SBC_IDLE;
                    else if (cnt_q == `SBC_FRAME_BITS) st_q <= sbc_pkg::SBC_DONE;
                    if (sck_rise) begin
                        miso_q <= tx_q[15];
                        tx_q   <= {tx_q[14:0], 1'b0};
                    end
                    if (sck_fall && cnt_q != 5'h1F) begin
                        rx_q  <= {rx_q[14:0], lk.mosi};
                        cnt_q <= cnt_q + 5'h01;
                        // data byte latched once address is in, before any write
                        if (cnt_q == 5'h07)
                            tx_q[15:8] <= sbc_read(rx_q[5:1]);  // [R2]
                    end
                end
                sbc_pkg::SBC_DONE: begin
                    if (sel_rise) st_q <= sbc_pkg::SBC_IDLE;
                    if (sck_fall) cnt_q <= 5'h1F;  // extra edge voids the frame [R22]
                end
                default: st_q <= sbc_pkg::SBC_IDLE;
            endcase
        end
    end
    assign o_link_miso    = miso_q;
    assign o_link_miso_oe = ~lk.sel_n;

    // register writes; overcurrent set beats clear
    wire hs_oc = i_hs_overcurrent;
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bridge_switch_q <= `SBC_RESET_VAL;  // [R11]
            hbctl_q  <= `SBC_RESET_VAL;
            system_control_reg_q <= `SBC_RESET_VAL;
            asel_q   <= `SBC_RESET_VAL;  // [R8]
            power_output_reg_q   <= `SBC_RESET_VAL;
            ocf_q    <= 1'b0;
        end else begin
            if (wr_ok) begin
                unique case (wr_addr)
                    `SBC_ADDR_BRIDGE: bridge_switch_q <= wr_data;
                    `SBC_ADDR_HBCTL:  hbctl_q  <= wr_data & `SBC_MASK_HBCTL;
                    `SBC_ADDR_SYSTEM_CONTROL_REG: system_control_reg_q <= wr_data & `SBC_MASK_SYSTEM_CONTROL_REG;
                    `SBC_ADDR_ASEL:   asel_q   <= wr_data & `SBC_MASK_ASEL;
                    `SBC_ADDR_POWER_OUTPUT_REG:   power_output_reg_q   <= wr_data & `SBC_MASK_POWER_OUTPUT_REG;
                    default: ;
                endcase
            end
            if (hs_oc || i_ls_overcurrent) ocf_q <= 1'b1;  // [R23]
            else if (wr_ok && wr_addr == `SBC_ADDR_STATUS && wr_data[`SBC_BIT_OCF])
                ocf_q <= 1'b0;  // [R23]
        end
    end

    // LIN path: driver only when enabled and tx low
    assign o_lin_drive = power_stages_enable & ~tx_s;  // [R3] [R6]
    assign o_lin_rx    = bus_s;         // [R7]
    assign o_analog_select = asel_q[3:0];  // [R8]
    assign o_switched_supply_output = power_output_reg_q[`SBC_BIT_SUPPLY] & power_stages_enable;  // [R9]
    assign o_current_limit_select = hbctl_q[2:0];  // [R17]

    // chopping: a latched off per low side, re-armed by the frequency edge
    wire limit_on = hbctl_q[2:0] >= `SBC_CLS_MIN;  // [R21]
    wire ofc = hbctl_q[`SBC_BIT_OFC];
    wire [3:0] rearm = ofc ? {fg_fall, fg_fall, fg_rise, fg_rise}  // [R19]
                           : {4{fg_rise}};                            // [R20]
    logic [3:0] chop_off_q, hs_q, ls_q;
    logic       ocf_hs_q, ocf_ls_q;
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            chop_off_q <= 4'h0;
            ocf_hs_q   <= 1'b0;
            ocf_ls_q   <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++)
                if (limit_on && lim_s2_q[i]) chop_off_q[i] <= 1'b1;  // [R16]
                else if (rearm[i] || !limit_on) chop_off_q[i] <= 1'b0;  // [R16]
            if (hs_oc) ocf_hs_q <= 1'b1;
            else if (!ocf_q) ocf_hs_q <= 1'b0;
            if (i_ls_overcurrent) ocf_ls_q <= 1'b1;
            else if (!ocf_q) ocf_ls_q <= 1'b0;
        end
    end

    // requested drive per bridge, high side first, then interlock
    logic [3:0] hs_req, ls_req;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            hs_req[i] = power_stages_enable & bridge_switch_q[2*i+1] & ~ocf_hs_q;  // [R12] [R13] [R14]
            ls_req[i] = power_stages_enable & bridge_switch_q[2*i] & ~bridge_switch_q[2*i+1]  // [R14]
                        & ~ocf_ls_q & ~chop_off_q[i];  // [R13] [R16]
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hs_q <= 4'h0;
            ls_q <= 4'h0;
        end else begin
            hs_q <= hs_req & ~ls_q & ls_off_s;  // [R15]
            ls_q <= ls_req & ~hs_q & hs_off_s;  // [R15]
        end
    end
    assign o_hs_on = hs_q;
    assign o_ls_on = ls_q;

    a_bridge_excl: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (hs_q & ls_q) == 4'h0) else $error("both sides of a bridge on");  // [R15]
    a_power_stages_enable_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !power_stages_enable |=> (hs_q == 4'h0 && ls_q == 4'h0)) else $error("drive without enable");  // [R13]
    a_hs_priority: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        bridge_switch_q[1] |=> !ls_q[0]) else $error("low side on with high bit");  // [R14]
    a_lin_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_lin_drive == (power_stages_enable && !$past(i_lin_tx, 2))) else $error("lin drive wrong");  // [R3]
    a_rx_follow: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_lin_rx == $past(i_lin_bus, 2)) else $error("rx mismatch");  // [R7]
    a_supply_on: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_switched_supply_output |-> power_output_reg_q[1]) else $error("supply on unexpectedly");  // [R9]
    a_short_frame: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (sel_rise && cnt_q != 5'd16)
        |=> $stable({bridge_switch_q, hbctl_q, system_control_reg_q, asel_q, power_output_reg_q}))
        else $error("write on bad frame");  // [R22]
    a_ocf_sticky: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (hs_oc || i_ls_overcurrent) |=> ocf_q) else $error("overcurrent flag missed");  // [R23]
    a_chop_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (chop_off_q[0] && !rearm[0] && limit_on) |=> chop_off_q[0])
        else $error("chop released early");  // [R16]
endmodule
`default_nettype wire

// ### tb/sbc_host_model.sv
`default_nettype none
// host side of the serial register link; sck idles low between frames
module sbc_host_model (
    // clock for edge alignment
    input  wire logic i_ref_clk,
    // serial link
    input  wire logic i_miso,
    output logic      o_sel_n,
    output logic      o_sck,
    output logic      o_mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sel_n = 1'b1;
        o_sck = 1'b0;
        o_mosi = 1'b0;
    end
    // one frame with a chosen edge count; 24 ns half period keeps edges clk-aligned
    task automatic xfer(input logic rw, input logic [4:0] addr, input logic [7:0] data,
                        input int edges, output logic [7:0] st, output logic [7:0] rd);
        logic [16:0] frm;
        logic [15:0] got;
        frm = {rw, addr, ^{rw, addr}, 1'b0, data, 1'b0};
        got = 16'h0000;
        @(posedge i_ref_clk);
        #1 o_sel_n = 1'b0;
        #24;
        for (int i = 0; i < edges; i++) begin
            o_sck = 1'b1;
            o_mosi = frm[16-i];
            #24;
            o_sck = 1'b0;
            got = {got[14:0], i_miso};
            #24;
        end
        o_sel_n = 1'b1;
        o_mosi = ~o_mosi; // released line, do not leave last bit standing
        #48;
        {st, rd} = got;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst = 1'b1, tx = 1'b1, bus = 1'b1, lcl = 1'b0;
    logic       hoc = 1'b0, loc = 1'b0, chop = 1'b0;
    logic [3:0] hgo = 4'hF, lgo = 4'hF, ovl = 4'h0, hs, ls, sel;
    logic       sel_n, sck, mosi, miso, oe, drv, rx, sup;
    logic [2:0] cls;
    logic [7:0] st, rd, v, ov;
    logic [4:0] ad [6] = '{5'h01, 5'h02, 5'h03, 5'h07, 5'h0B, 5'h0C};
    int         bad_count = 0, checks = 0, seed = 15, k;

    sbc_ctrl u_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_link_sel_n(sel_n),
        .i_link_sck(sck), .i_link_mosi(mosi), .o_link_miso(miso), .o_link_miso_oe(oe),
        .i_lin_tx(tx), .i_lin_bus(bus), .i_lin_climit(lcl), .o_lin_drive(drv),
        .o_lin_rx(rx), .o_analog_select(sel), .o_switched_supply_output(sup),
        .i_hs_gate_off(hgo), .i_ls_gate_off(lgo), .i_ls_over_limit(ovl),
        .i_hs_overcurrent(hoc), .i_ls_overcurrent(loc), .i_chop_frequency_input(chop),
        .o_hs_on(hs), .o_ls_on(ls), .o_current_limit_select(cls));
    sbc_host_model u_host (.i_ref_clk(clk), .i_miso(miso), .o_sel_n(sel_n),
        .o_sck(sck), .o_mosi(mosi));

    always #2 clk = ~clk;

    task automatic end_sim;
        if (bad_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic xf(input logic r, input logic [4:0] a, input logic [7:0] d, input int e = 16);
        u_host.xfer(r, a, d, e, st, rd);
    endtask
    // lets the input synchronisers and gate registers catch up
    task automatic sl(input int n = 8);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // high side wins; low side needs its partner confirmed off
    function automatic logic [7:0] exp_br(input logic [7:0] hb, input logic [3:0] hg,
                                          input logic [3:0] lg);
        logic [3:0] h, l;
        for (int i = 0; i < 4; i++) begin
            h[i] = hb[2*i+1] & lg[i];
            l[i] = hb[2*i] & ~hb[2*i+1] & hg[i];
        end
        return {h, l};
    endfunction

    initial begin
        #400000;
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        sl();
        chk({hs, ls}, 8'h00, "bridges after reset");
        chk({7'h00, oe}, 8'h00, "miso enable idle");
        for (k = 0; k < 6; k++) begin
            xf(1'b1, ad[k], 8'($random(seed)));
            chk(st, 8'h00, "status byte");
            chk(rd, 8'h00, "reset value");
        end
        // mux codes, random upper bits must be masked
        ov = 8'h00;
        for (k = 0; k < 16; k++) begin
            v = 8'($random(seed));
            v[3:0] = k[3:0];
            xf(1'b0, 5'h07, v);
            chk(rd, ov, "old value on write");
            ov = {4'h0, v[3:0]};
            sl();
            chk({4'h0, sel}, ov, "mux select");
        end
        xf(1'b0, 5'h07, 8'h05, 15);
        xf(1'b0, 5'h07, 8'h06, 17);
        xf(1'b1, 5'h07, 8'h00);
        chk(rd, ov, "short or long frame");
        for (k = 0; k < 4; k++) begin
            xf(1'b0, 5'h03, {k[1], 7'h00});
            xf(1'b0, 5'h0B, {6'h00, k[0], 1'b0});
            tx = 1'($random(seed));
            bus = 1'($random(seed));
            lcl = 1'b1;
            sl();
            chk({5'h00, sup, drv, rx}, {5'h00, k[0] & k[1], k[1] & ~tx, bus},
                "supply lin");
            xf(1'b1, 5'h0C, 8'h00);
            chk(st, {1'b0, k[1], 6'h00}, "lin limit flag");
        end
        xf(1'b0, 5'h03, 8'h00);
        lcl = 1'b0;
        xf(1'b0, 5'h03, 8'h80);
        ov = 8'h00;
        for (k = 0; k < 12; k++) begin
            v = 8'($random(seed));
            hgo = (k < 8) ? 4'hF : 4'($random(seed));
            lgo = (k < 8) ? 4'hF : 4'($random(seed));
            xf(1'b0, 5'h01, v);
            chk(rd, ov, "bridge old value");
            ov = v;
            sl();
            chk({hs, ls}, exp_br(v, hgo, lgo), "bridge drive");
        end
        {hgo, lgo} = 8'hFF;
        xf(1'b0, 5'h03, 8'h00);
        sl();
        chk({hs, ls}, 8'h00, "stages disabled");
        // overcurrent on one side, then clear by writing one
        xf(1'b0, 5'h03, 8'h80);
        xf(1'b0, 5'h01, 8'hA5);
        for (k = 0; k < 2; k++) begin
            {hoc, loc} = k[0] ? 2'b01 : 2'b10;
            sl();
            {hoc, loc} = 2'b00;
            xf(1'b1, 5'h0C, 8'h00);
            chk(st, 8'h02, "overcurrent flag");
            chk({hs, ls}, k[0] ? 8'hC0 : 8'h03, "overcurrent off");
            xf(1'b0, 5'h0C, 8'h02);
            sl();
            chk({hs, ls}, 8'hC3, "overcurrent cleared");
        end
        // every limit code, with and without offset chopping
        xf(1'b0, 5'h01, 8'h55);
        for (k = 0; k < 16; k++) begin
            xf(1'b0, 5'h02, {k[3], 4'h0, k[2:0]});
            ovl = 4'hF;
            sl();
            ovl = 4'h0;
            sl();
            chk({1'b0, cls, ls}, {1'b0, k[2:0], (k[2:0] > 2) ? 4'h0 : 4'hF},
                "limit");
            // last pass runs one full period at the top of the allowed chop range
            chop = 1'b1;
            sl((k == 15) ? 6250 : 8);
            chk({4'h0, ls}, (k[2:0] > 2 && k[3]) ? 8'h03 : 8'h0F,
                "rising re-arm");
            chop = 1'b0;
            sl((k == 15) ? 6250 : 8);
            chk({4'h0, ls}, 8'h0F, "falling re-arm");
        end
        end_sim();
    end
endmodule
`default_nettype wire
